// >>> rtl/vfd_scan_controller.sv
// Dynamic scan controller for a multiplexed fluorescent display.
//
// Function
// R1: Slot lasts 1024 or 2048 clocks, chosen by dimmer bit 0.
// R2: Full scan spans digit-select value plus two slots.
// R3: Digit strobe shortened by dimmer bits 3..1 cut fraction.
// R4: Dynamic display runs only while config bit 3 is set.
// R5: Config bits 2..0 give nine plus value dynamic segments.
// R6: High eight segment pins add eight segments when dynamic.
// R7: Scan N plus one digits, N being the digit-select value.
// R8: Software never writes digit-select values zero to seven.
// R9: Reset loads digit-select with eight, nine digits.
// R10: Reset clears config, dimmer and both static registers.
// R11: Software disables display before standby or slow clock.
// R12: Software writes 4-bit registers as nibbles, static ones as bytes.
// R13: Static low register all ones drives pins 0-15 from port data.
// R14: Software sets static low bits all alike.
// R15: Static high bits 5..4 choose dynamic or port data for 16-23.
// R16: Software sets static high bits 5..4 alike.
// R17: Segment data fetched autonomously from display memory.
// R18: Display memory takes bit, nibble and even-address byte accesses.
// R19: Key-scan buffers output on segments during key-scan slot.
// R20: Raise key-scan interrupt request at the key-scan slot.
// R21: Strobes one at a time ascending, then key-scan slot.
`timescale 1ns/100ps
`default_nettype none
module vfd_scan_controller (
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              sys_rst_i,
  // Processor data-space access
  input  wire vfd_pkg::cpu_req_s req_i,
  output logic [7:0]             rd_data_o,
  output logic                   rd_valid_o,
  // Port latch data for static pins
  input  wire logic [15:0]       port_low_i,
  input  wire logic [7:0]        port_high_i,
  // Display pins
  output logic [15:0]            digit_strobe_out_o,
  output logic [23:0]            segment_out_o,
  output logic                   key_scan_irq_o
);
  import vfd_pkg::*;

  logic [3:0]  display_config_reg;
  logic [3:0]  digit_count_reg;
  logic [3:0]  dimmer_reg;
  logic [3:0]  static_sel_low_reg;
  logic [1:0]  static_sel_high_reg;
  scan_state_e state;
  logic [11:0] slot_cnt;
  logic [3:0]  slot_idx;
  logic [11:0] slot_len;
  logic        slot_end;
  logic [3:0]  phase;
  logic [4:0]  cut_units;
  logic        strobe_on;
  logic [15:0] seg_mask_low;
  logic [4:0]  seg_count;
  logic        static_low;
  logic        static_high;
  logic        display_en;
  logic        mem_hit;
  logic        mem_ok;
  logic [7:0]  mem_rdata;
  logic [3:0]  row_sel;
  logic [23:0] row;
  logic [15:0] next_strobe;
  logic [23:0] next_segment;
  logic [23:0] dyn_seg;

  function automatic logic [3:0] nib_upd(input logic [3:0] old,
                                         input cpu_req_s   r);
    logic [3:0] v;
    v = old;
    if (r.size == ACC_NIBBLE) begin
      v = r.wdata[3:0];
    end else if (r.size == ACC_BIT) begin
      v[r.bit_sel] = r.wdata[0];
    end
    return v;
  endfunction : nib_upd

  // Register file.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      display_config_reg  <= DISPLAY_CONFIG_RST; // R10
      digit_count_reg     <= DIGIT_COUNT_RST; // R9
      dimmer_reg          <= DIMMER_RST; // R10
      static_sel_low_reg  <= STATIC_LOW_RST; // R10
      static_sel_high_reg <= STATIC_HIGH_RST; // R10
    end else if (req_i.wr) begin
      case (req_i.addr)
        ADDR_DISPLAY_CONFIG:
          display_config_reg <= nib_upd(display_config_reg, req_i);
        ADDR_DIGIT_COUNT:
          digit_count_reg <= nib_upd(digit_count_reg, req_i);
        ADDR_DIMMER:
          dimmer_reg <= nib_upd(dimmer_reg, req_i);
        // Static registers only take whole-byte writes.
        ADDR_STATIC_LOW:
          if (req_i.size == ACC_BYTE) begin
            static_sel_low_reg <= req_i.wdata[3:0];
          end
        ADDR_STATIC_HIGH:
          if (req_i.size == ACC_BYTE) begin
            static_sel_high_reg <= req_i.wdata[STATIC_SEL_HIGH_REG_LSB +: 2];
          end
        default: ;
      endcase
    end
  end

  // Display memory: odd-address byte accesses are refused.
  assign mem_hit = (req_i.addr >= MEM_BASE) && (req_i.addr <= MEM_LAST);
  assign mem_ok  = mem_hit &&
                   !((req_i.size == ACC_BYTE) && req_i.addr[0]); // R18

  display_memory u_mem (
    .clock_i   (clock_i),
    .req_i     (req_i),
    .wr_en_i   (req_i.wr && mem_ok),
    .rd_data_o (mem_rdata),
    .row_sel_i (row_sel),
    .row_o     (row)
  );

  // Read answers one cycle after the request; unmapped reads give zero.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rd_data_o  <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= req_i.rd;
      if (mem_ok) begin
        rd_data_o <= mem_rdata;
      end else begin
        case (req_i.addr)
          ADDR_DISPLAY_CONFIG: rd_data_o <= {4'h0, display_config_reg};
          ADDR_DIGIT_COUNT:    rd_data_o <= {4'h0, digit_count_reg};
          ADDR_DIMMER:         rd_data_o <= {4'h0, dimmer_reg};
          ADDR_STATIC_LOW:     rd_data_o <= {4'h0, static_sel_low_reg};
          ADDR_STATIC_HIGH:
            rd_data_o <= {2'b00, static_sel_high_reg, 4'h0};
          default:             rd_data_o <= 8'h00;
        endcase
      end
    end
  end

  // Scan timing.
  assign display_en = display_config_reg[EN_BIT];
  assign slot_len   = dimmer_reg[SLOT_SEL_BIT] ? SLOT_LONG_CYC
                                               : SLOT_SHORT_CYC; // R1
  assign slot_end   = (slot_cnt >= slot_len - 12'h001);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !display_en) begin // R4
      state    <= SCAN_OFF;
      slot_cnt <= 12'h000;
      slot_idx <= 4'h0;
    end else begin
      slot_cnt <= slot_end ? 12'h000 : slot_cnt + 12'h001; // R1
      case (state)
        SCAN_OFF: begin
          state    <= SCAN_DIGIT;
          slot_cnt <= 12'h000;
        end
        SCAN_DIGIT:
          if (slot_end) begin
            // A lowered digit count ends the digit run at the end of the current slot.
            if (slot_idx >= digit_count_reg) begin // R7
              state <= SCAN_KEY; // R2
            end else begin
              slot_idx <= slot_idx + 4'h1; // R21
            end
          end
        SCAN_KEY:
          if (slot_end) begin
            state    <= SCAN_DIGIT; // R2
            slot_idx <= 4'h0;
          end
        default: state <= SCAN_OFF;
      endcase
    end
  end

  // Strobe stays on for the uncut sixteenths at the slot start.
  assign phase     = dimmer_reg[SLOT_SEL_BIT] ? slot_cnt[10:7]
                                               : slot_cnt[9:6];
  assign cut_units = (dimmer_reg[CUT_LSB +: 3] == 3'b000) ? 5'h01
                     : {1'b0, dimmer_reg[CUT_LSB +: 3], 1'b0}; // R3
  assign strobe_on = {1'b0, phase} < (SIXTEENTHS - cut_units); // R3

  assign seg_count = MIN_SEGMENTS +
                     {2'b00, display_config_reg[SEG_CNT_LSB +: 3]}; // R5
  for (genvar s = 0; s < 16; s++) begin : g_mask
    assign seg_mask_low[s] = (5'(s) < seg_count); // R5
  end

  assign static_low  = &static_sel_low_reg; // R13
  assign static_high = &static_sel_high_reg; // R15
  assign row_sel     = (state == SCAN_KEY) ? KEY_ROW : slot_idx; // R19

  always_comb begin
    next_strobe = 16'h0000;
    dyn_seg     = 24'h000000;
    // The enable gate darkens the pins one cycle after a disabling write.
    if (display_en && state == SCAN_DIGIT && strobe_on &&
        slot_idx <= digit_count_reg) begin // R4 R7
      next_strobe[slot_idx] = 1'b1; // R21
      dyn_seg               = row; // R17
    end else if (display_en && state == SCAN_KEY) begin
      dyn_seg = row; // R19
    end
    // Pins left out of the dynamic count stay low.
    dyn_seg[15:0]  = dyn_seg[15:0] & seg_mask_low; // R5
    dyn_seg[23:16] = static_high ? 8'h00 : dyn_seg[23:16]; // R6
    next_segment[15:0]  = static_low ? port_low_i : dyn_seg[15:0]; // R13
    next_segment[23:16] = static_high ? port_high_i
                                      : dyn_seg[23:16]; // R15
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      digit_strobe_out_o <= 16'h0000;
      segment_out_o      <= 24'h000000;
      key_scan_irq_o     <= 1'b0;
    end else begin
      digit_strobe_out_o <= next_strobe;
      segment_out_o      <= next_segment;
      key_scan_irq_o     <= (state == SCAN_DIGIT) && slot_end &&
                            (slot_idx >= digit_count_reg); // R20
    end
  end

  // Helper logic for the checks below.
  logic        cfg_quiet;
  logic [15:0] gap_cnt;
  logic [11:0] hi_cnt;
  logic [15:0] exp_gap;
  logic [11:0] exp_hi;
  logic [4:0]  n_slots;

  assign n_slots = {1'b0, digit_count_reg} + 5'h02;
  assign exp_gap = {4'h0, slot_len} * {11'h000, n_slots};
  assign exp_hi  = {7'h00, SIXTEENTHS - cut_units} <<
                   (dimmer_reg[SLOT_SEL_BIT] ? 7 : 6);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || req_i.wr) begin
      cfg_quiet <= 1'b0;
    end else if (key_scan_irq_o) begin
      cfg_quiet <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      gap_cnt <= 16'h0000;
      hi_cnt  <= 12'h000;
    end else begin
      gap_cnt <= key_scan_irq_o ? 16'h0001 : gap_cnt + 16'h0001;
      hi_cnt  <= (|digit_strobe_out_o) ? hi_cnt + 12'h001 : 12'h000;
    end
  end

  property p_slot_short;
    @(posedge clock_i) disable iff (sys_rst_i)
    (state == SCAN_DIGIT && !dimmer_reg[0] && display_en &&
     slot_cnt == 12'h3ff) |=> (slot_cnt == 12'h000);
  endproperty
  a_slot_short: assert property (p_slot_short) // R1
    else $error("short slot did not end after 1024 cycles");

  property p_scan_period;
    @(posedge clock_i) disable iff (sys_rst_i)
    (key_scan_irq_o && cfg_quiet) |-> (gap_cnt == exp_gap);
  endproperty
  a_scan_period: assert property (p_scan_period) // R2
    else $error("scan period differs from slot length times N+2");

  property p_strobe_width;
    @(posedge clock_i) disable iff (sys_rst_i)
    ($fell(|digit_strobe_out_o) && cfg_quiet && display_en)
      |-> (hi_cnt == exp_hi);
  endproperty
  a_strobe_width: assert property (p_strobe_width) // R3
    else $error("digit strobe width does not match cut setting");

  property p_disabled_dark;
    @(posedge clock_i) disable iff (sys_rst_i)
    !display_en [*2] |-> (digit_strobe_out_o == 16'h0000);
  endproperty
  a_disabled_dark: assert property (p_disabled_dark) // R4
    else $error("digit strobe active while display disabled");

  property p_seg_mask;
    @(posedge clock_i) disable iff (sys_rst_i)
    !static_low |=> ((segment_out_o[15:0] & ~$past(seg_mask_low))
                     == 16'h0000);
  endproperty
  a_seg_mask: assert property (p_seg_mask) // R5
    else $error("segment above configured count driven");

  property p_digit_limit;
    @(posedge clock_i) disable iff (sys_rst_i)
    $stable(digit_count_reg) |=>
      ((digit_strobe_out_o >> ({1'b0, digit_count_reg} + 5'h01))
       == 16'h0000);
  endproperty
  a_digit_limit: assert property (p_digit_limit) // R7
    else $error("strobe beyond selected digit count");

  property p_reset_digits;
    @(posedge clock_i)
    $past(sys_rst_i) |-> (digit_count_reg == 4'h8);
  endproperty
  a_reset_digits: assert property (p_reset_digits) // R9
    else $error("digit select not eight after reset");

  property p_reset_clear;
    @(posedge clock_i)
    $past(sys_rst_i) |-> (display_config_reg == 4'h0 &&
      dimmer_reg == 4'h0 && static_sel_low_reg == 4'h0 &&
      static_sel_high_reg == 2'h0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) // R10
    else $error("control register not clear after reset");

  property p_static_low;
    @(posedge clock_i) disable iff (sys_rst_i)
    static_low |=> (segment_out_o[15:0] == $past(port_low_i));
  endproperty
  a_static_low: assert property (p_static_low) // R13
    else $error("static low pins do not follow port data");

  property p_static_high;
    @(posedge clock_i) disable iff (sys_rst_i)
    static_high |=> (segment_out_o[23:16] == $past(port_high_i));
  endproperty
  a_static_high: assert property (p_static_high) // R15
    else $error("static high pins do not follow port data");

  property p_irq_pulse;
    @(posedge clock_i) disable iff (sys_rst_i)
    key_scan_irq_o |=> !key_scan_irq_o [*8];
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) // R20
    else $error("key scan request longer than one cycle");

  property p_one_strobe;
    @(posedge clock_i) disable iff (sys_rst_i)
    $onehot0(digit_strobe_out_o);
  endproperty
  a_one_strobe: assert property (p_one_strobe) // R21
    else $error("more than one digit strobe active");

  c_irq: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    key_scan_irq_o && cfg_quiet);
  c_long_strobe: cover property (@(posedge clock_i)
    disable iff (sys_rst_i)
    $fell(|digit_strobe_out_o) && dimmer_reg[0]);
  c_static: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    static_low && static_high && display_en);
endmodule : vfd_scan_controller
`default_nettype wire

// >>> rtl/vfd_pkg.sv
// Shared constants and types for the display scan controller.
package vfd_pkg;
  // Register addresses in the nibble-addressed data space.
  localparam logic [11:0] ADDR_DISPLAY_CONFIG = 12'hf88;
  localparam logic [11:0] ADDR_DIGIT_COUNT    = 12'hf8a;
  localparam logic [11:0] ADDR_DIMMER         = 12'hf8c;
  localparam logic [11:0] ADDR_STATIC_LOW     = 12'hfd6;
  localparam logic [11:0] ADDR_STATIC_HIGH    = 12'hfd8;
  // Display data memory window.
  localparam logic [11:0] MEM_BASE  = 12'h1a0;
  localparam logic [11:0] MEM_LAST  = 12'h1ff;
  localparam int          MEM_WORDS = 96;
  localparam logic [6:0]  ROW_LOW_BASE = 7'h20;
  // Reset values.
  localparam logic [3:0] DISPLAY_CONFIG_RST = 4'h0;
  localparam logic [3:0] DIGIT_COUNT_RST    = 4'h8;
  localparam logic [3:0] DIMMER_RST         = 4'h0;
  localparam logic [3:0] STATIC_LOW_RST     = 4'h0;
  localparam logic [1:0] STATIC_HIGH_RST    = 2'h0;
  // Field positions.
  localparam int EN_BIT        = 3;
  localparam int SEG_CNT_LSB   = 0;
  localparam int SLOT_SEL_BIT  = 0;
  localparam int CUT_LSB       = 1;
  localparam int STATIC_SEL_HIGH_REG_LSB     = 4;
  // Timing: slot lengths in main clock periods; clock_i is that clock.
  localparam int          FX_PER_CLOCK   = 1;
  localparam int          SLOT_SHORT_FX  = 1024;
  localparam int          SLOT_LONG_FX   = 2048;
  localparam logic [11:0] SLOT_SHORT_CYC = 12'(SLOT_SHORT_FX / FX_PER_CLOCK);
  localparam logic [11:0] SLOT_LONG_CYC  = 12'(SLOT_LONG_FX / FX_PER_CLOCK);
  localparam logic [4:0]  SIXTEENTHS     = 5'h10;
  localparam logic [4:0]  MIN_SEGMENTS   = 5'h09;
  localparam logic [3:0]  KEY_ROW        = 4'hf;

  typedef enum logic [1:0] {
    ACC_BIT    = 2'b00,
    ACC_NIBBLE = 2'b01,
    ACC_BYTE   = 2'b10
  } access_size_e;

  typedef enum logic [1:0] {
    SCAN_OFF   = 2'b00,
    SCAN_DIGIT = 2'b01,
    SCAN_KEY   = 2'b10
  } scan_state_e;

  typedef struct packed {
    logic [11:0]  addr;
    access_size_e size;
    logic [1:0]   bit_sel;
    logic         wr;
    logic         rd;
    logic [7:0]   wdata;
  } cpu_req_s;
endpackage : vfd_pkg

// >>> rtl/display_memory.sv
// Display data memory with a processor port and a row fetch port.
`timescale 1ns/100ps
`default_nettype none
module display_memory (
  // Clock
  input  wire logic            clock_i,
  // Processor access
  input  wire vfd_pkg::cpu_req_s req_i,
  input  wire logic            wr_en_i,
  output logic [7:0]           rd_data_o,
  // Row fetch for the scanner
  input  wire logic [3:0]      row_sel_i,
  output logic [23:0]          row_o
);
  import vfd_pkg::*;

  logic [3:0] mem [0:MEM_WORDS-1];
  logic [6:0] idx;
  logic [6:0] idx_next;

  assign idx      = 7'(req_i.addr - MEM_BASE);
  assign idx_next = idx + 7'h01;

  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      case (req_i.size)
        ACC_BIT:    mem[idx][req_i.bit_sel] <= req_i.wdata[0];
        ACC_NIBBLE: mem[idx] <= req_i.wdata[3:0];
        ACC_BYTE: begin
          mem[idx]      <= req_i.wdata[3:0];
          mem[idx_next] <= req_i.wdata[7:4];
        end
        default: ;
      endcase
    end
  end

  assign rd_data_o = (req_i.size == ACC_BYTE) ? {mem[idx_next], mem[idx]}
                                              : {4'h0, mem[idx]};

  // Segments 0..15 sit four nibbles per row above the high-pin area.
  for (genvar g = 0; g < 4; g++) begin : g_row_low
    assign row_o[4*g +: 4] =
      mem[ROW_LOW_BASE + {1'b0, row_sel_i, 2'(g)}];
  end
  for (genvar h = 0; h < 2; h++) begin : g_row_high
    assign row_o[16 + 4*h +: 4] = mem[{2'b00, row_sel_i, 1'(h)}];
  end
endmodule : display_memory
`default_nettype wire

// >>> testbench/vfd_panel_model.sv
// Display panel model that watches strobes and segments and times them.
`timescale 1ns/100ps
`default_nettype none
module vfd_panel_model (
  // Clock
  input  wire logic        clock_i,
  // Display pins
  input  wire logic [15:0] digit_strobe_out_o,
  input  wire logic [23:0] segment_out_o,
  input  wire logic        key_scan_irq_o,
  // Observations
  output logic             rise_evt,
  output logic [3:0]       rise_digit,
  output logic [23:0]      rise_segs,
  output logic [15:0]      width,
  output logic [15:0]      gap,
  output logic [15:0]      slot_gap,
  output logic [15:0]      irq_offset,
  output logic [23:0]      key_segs,
  output logic             order_bad
);
  logic [15:0] prev;
  logic [15:0] hi_cnt;
  logic [15:0] scan_cnt;
  logic [15:0] slot_cnt;
  logic        irq_d;
  logic [3:0]  idx;

  always_comb begin
    idx = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (digit_strobe_out_o[i]) begin
        idx = 4'(i);
      end
    end
  end

  initial begin
    order_bad = 1'b0;
  end

  // Counters start unknown and become meaningful after the first strobe.
  always @(posedge clock_i) begin
    rise_evt <= 1'b0;
    prev     <= digit_strobe_out_o;
    hi_cnt   <= hi_cnt + 16'h1;
    scan_cnt <= scan_cnt + 16'h1;
    slot_cnt <= slot_cnt + 16'h1;
    irq_d    <= key_scan_irq_o;
    if (!$onehot0(digit_strobe_out_o)) begin
      order_bad <= 1'b1;
    end
    if (digit_strobe_out_o != 16'h0 && digit_strobe_out_o != prev) begin
      rise_evt   <= 1'b1;
      rise_digit <= idx;
      rise_segs  <= segment_out_o;
      hi_cnt     <= 16'h1;
      slot_cnt   <= 16'h1;
      slot_gap   <= slot_cnt;
      if (idx != 4'h0 && idx != rise_digit + 4'h1) begin
        order_bad <= 1'b1;
      end
      if (idx == 4'h0) begin
        scan_cnt <= 16'h1;
        gap      <= scan_cnt;
      end
    end
    if (digit_strobe_out_o == 16'h0 && prev != 16'h0) begin
      width <= hi_cnt;
    end
    if (key_scan_irq_o) begin
      irq_offset <= scan_cnt;
    end
    if (irq_d) begin
      key_segs <= segment_out_o;
    end
  end
endmodule : vfd_panel_model
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the display scan controller.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import vfd_pkg::*;
  localparam cpu_req_s IDLE = '0;
  logic        clock_i;
  logic        sys_rst_i;
  cpu_req_s    req_i;
  logic [7:0]  rd_data_o;
  logic        rd_valid_o;
  logic [15:0] port_low_i;
  logic [7:0]  port_high_i;
  logic [15:0] digit_strobe_out_o;
  logic [23:0] segment_out_o;
  logic        key_scan_irq_o;
  logic        rise_evt;
  logic [3:0]  rise_digit;
  logic [23:0] rise_segs;
  logic [15:0] width;
  logic [15:0] gap;
  logic [15:0] slot_gap;
  logic [15:0] irq_offset;
  logic [23:0] key_segs;
  logic        order_bad;
  logic [15:0] seen_any;
  int          err_total;
  int          samples_checked;
  int          slot_s;
  int          slot_l;
  int          n0;
  int          cut16 [8] = '{1, 2, 4, 6, 8, 10, 12, 14};

  vfd_scan_controller dut_u (
    .clock_i            (clock_i),
    .sys_rst_i          (sys_rst_i),
    .req_i              (req_i),
    .rd_data_o          (rd_data_o),
    .rd_valid_o         (rd_valid_o),
    .port_low_i         (port_low_i),
    .port_high_i        (port_high_i),
    .digit_strobe_out_o (digit_strobe_out_o),
    .segment_out_o      (segment_out_o),
    .key_scan_irq_o     (key_scan_irq_o)
  );

  vfd_panel_model panel_u (
    .clock_i            (clock_i),
    .digit_strobe_out_o (digit_strobe_out_o),
    .segment_out_o      (segment_out_o),
    .key_scan_irq_o     (key_scan_irq_o),
    .rise_evt           (rise_evt),
    .rise_digit         (rise_digit),
    .rise_segs          (rise_segs),
    .width              (width),
    .gap                (gap),
    .slot_gap           (slot_gap),
    .irq_offset         (irq_offset),
    .key_segs           (key_segs),
    .order_bad          (order_bad)
  );

  initial begin
    clock_i = 1'b0;
  end
  always #2 clock_i = ~clock_i;

  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic send(input logic [11:0] a, input access_size_e s,
                      input logic [1:0] b, input logic w, input logic [7:0] d);
    @(posedge clock_i);
    req_i <= '{addr: a, size: s, bit_sel: b, wr: w, rd: !w, wdata: d};
    @(posedge clock_i);
    req_i <= IDLE;
  endtask : send

  task automatic wr(input logic [11:0] a, input access_size_e s,
                    input logic [7:0] d);
    send(a, s, 2'h0, 1'b1, d);
  endtask : wr

  // Read data is looked at just after the edge that raises the valid pulse.
  task automatic rdc(input string what, input logic [11:0] a,
                     input access_size_e s, input logic [7:0] exp);
    send(a, s, 2'h0, 1'b0, 8'h00);
    #1;
    chk(what, {15'h0, 1'b1, exp}, {15'h0, rd_valid_o, rd_data_o});
  endtask : rdc

  // A negative digit matches the next strobe of any digit.
  task automatic wait_digit(input int d);
    int n;
    n = 0;
    @(posedge clock_i);
    while (!(rise_evt === 1'b1 && (d < 0 || rise_digit === 4'(d)))
           && n < 40000) begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 40000) begin
      err_total++;
      $display("[ERR] strobe of digit %0d expected 1 seen 0", d);
    end
  endtask : wait_digit

  task report_and_stop;
    $display("Counts: %0d compared, %0d mismatched", samples_checked,
             err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // The full run needs about 81k cycles, so this limit leaves margin.
  initial begin
    repeat (98000) @(posedge clock_i);
    err_total++;
    $display("[ERR] run length expected done seen timeout");
    report_and_stop();
  end

  initial begin
    err_total = 0;
    samples_checked = 0;
    slot_s = int'(SLOT_SHORT_CYC);
    slot_l = int'(SLOT_LONG_CYC);
    n0 = int'(DIGIT_COUNT_RST);
    sys_rst_i = 1'b1;
    req_i = IDLE;
    port_low_i = 16'h0;
    port_high_i = 8'h0;
    repeat (8) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rdc("display_config", ADDR_DISPLAY_CONFIG, ACC_NIBBLE, 8'h00);
    rdc("digit_count_select", ADDR_DIGIT_COUNT, ACC_NIBBLE, 8'h08);
    rdc("dimmer_select", ADDR_DIMMER, ACC_NIBBLE, 8'h00);
    rdc("static_low", ADDR_STATIC_LOW, ACC_BYTE, 8'h00);
    rdc("static_high", ADDR_STATIC_HIGH, ACC_BYTE, 8'h00);
    chk("strobes after reset", 24'h0, {8'h0, digit_strobe_out_o});
    $display("Test reset_values done");

    wr(ADDR_DISPLAY_CONFIG, ACC_BYTE, 8'h0f);
    rdc("config byte", ADDR_DISPLAY_CONFIG, ACC_NIBBLE, 8'h00);
    wr(12'h1c4, ACC_BYTE, 8'h5a);
    rdc("low nibble", 12'h1c4, ACC_NIBBLE, 8'h0a);
    rdc("high nibble", 12'h1c5, ACC_NIBBLE, 8'h05);
    rdc("even byte", 12'h1c4, ACC_BYTE, 8'h5a);
    wr(12'h1c7, ACC_BYTE, 8'hff);
    rdc("odd byte", 12'h1c7, ACC_BYTE, 8'h00);
    wr(12'h1c6, ACC_NIBBLE, 8'h00);
    send(12'h1c6, ACC_BIT, 2'h2, 1'b1, 8'h01);
    rdc("bit write", 12'h1c6, ACC_NIBBLE, 8'h04);
    rdc("unmapped", 12'h300, ACC_NIBBLE, 8'h00);
    $display("Test access done");

    port_low_i <= 16'h1234;
    port_high_i <= 8'ha5;
    wr(ADDR_STATIC_LOW, ACC_BYTE, 8'h0f);
    wr(ADDR_STATIC_HIGH, ACC_BYTE, 8'h30);
    rdc("static low set", ADDR_STATIC_LOW, ACC_BYTE, 8'h0f);
    chk("static pins", 24'ha51234, segment_out_o);
    wr(ADDR_STATIC_LOW, ACC_BYTE, 8'h00);
    wr(ADDR_STATIC_HIGH, ACC_BYTE, 8'h00);
    $display("Test static done");

    wr(12'h1c0, ACC_BYTE, 8'hff);
    wr(12'h1c2, ACC_BYTE, 8'hff);
    wr(12'h1a0, ACC_BYTE, 8'hc3);
    wr(12'h1fc, ACC_BYTE, 8'h21);
    wr(12'h1fe, ACC_BYTE, 8'h43);
    wr(12'h1be, ACC_BYTE, 8'h65);
    wr(ADDR_DISPLAY_CONFIG, ACC_NIBBLE, 8'h0f);
    wait_digit(0);
    chk("row0 segments", 24'hc3ffff, rise_segs);
    wait_digit(1);
    chk("short slot", 24'(slot_s), {8'h0, slot_gap});
    wait_digit(0);
    chk("scan period", 24'((n0 + 2) * slot_s), {8'h0, gap});
    // The key request leads the key data on the pins by one cycle.
    chk("irq offset", 24'((n0 + 1) * slot_s - 1), {8'h0, irq_offset});
    chk("key segments", 24'h654321, key_segs);
    chk("strobe order", 24'h0, {23'h0, order_bad});
    wr(ADDR_STATIC_HIGH, ACC_BYTE, 8'h30);
    wr(ADDR_DISPLAY_CONFIG, ACC_NIBBLE, 8'h08);
    wait_digit(0);
    chk("masked segments", 24'ha501ff, rise_segs);
    wr(ADDR_STATIC_HIGH, ACC_BYTE, 8'h00);
    $display("Test scan done");

    for (int i = 0; i < 8; i++) begin
      wr(ADDR_DIMMER, ACC_NIBBLE, 8'(i << 1));
      wait_digit(-1);
      wait_digit(-1);
      chk("cut width", 24'((16 - cut16[i]) * slot_s / 16), {8'h0, width});
    end
    wr(ADDR_DIMMER, ACC_NIBBLE, 8'h01);
    wait_digit(0);
    wait_digit(1);
    chk("long slot", 24'(slot_l), {8'h0, slot_gap});
    chk("long width", 24'(15 * slot_l / 16), {8'h0, width});
    wr(ADDR_DIMMER, ACC_NIBBLE, 8'h00);
    $display("Test dimmer done");

    wr(ADDR_DIGIT_COUNT, ACC_NIBBLE, 8'h0f);
    wait_digit(0);
    wait_digit(15);
    wait_digit(0);
    chk("period 16 digits", 24'(17 * slot_s), {8'h0, gap});
    chk("irq 16 digits", 24'(16 * slot_s - 1), {8'h0, irq_offset});
    chk("order 16 digits", 24'h0, {23'h0, order_bad});
    wr(ADDR_DISPLAY_CONFIG, ACC_NIBBLE, 8'h00);
    seen_any = 16'h0;
    repeat (1100) begin
      @(posedge clock_i);
      #1;
      seen_any = seen_any | digit_strobe_out_o;
    end
    chk("strobes disabled", 24'h0, {8'h0, seen_any});
    $display("Test digits_and_disable done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
